// *** core/psv_pkg.sv ***
// Package: register map, field positions and mode states of the power-save controller
`default_nettype none
package psv_pkg;

	// ==========================================================
	// Register map (byte addresses on the Wishbone bus)
	localparam logic [7:0] ADDR_SAVE = 8'h00;
	localparam logic [7:0] ADDR_CFG = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;

	// ==========================================================
	// Power-save control register fields
	localparam int STOP_REQ_BIT = 0;
	localparam int IDLE_REQ_BIT = 1;

	// ==========================================================
	// Clock-source configuration register fields
	localparam int CFG_W = 9;
	localparam int CFG_WA_WTI = 0;
	localparam int CFG_NC_SUB = 1;
	localparam int CFG_ND_SUB = 2;
	localparam int CFG_WT_SUB = 3;
	localparam int CFG_CSI_EXT = 4;
	localparam int CFG_UA_EXT = 5;
	localparam int CFG_UB_EXT = 6;
	localparam int CFG_RTP_C = 7;
	localparam int CFG_RTP_D = 8;
	localparam logic [CFG_W-1:0] CFG_RESET = 9'h000;

	// ==========================================================
	// Status register fields
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_SUB_PRESENT = 2;
	localparam int STAT_CPU_ON_SUB = 3;
	localparam int STAT_MAIN_OSC = 4;

	// ==========================================================
	// Peripheral wake-request vector layout
	localparam int IRQ_W = 7;
	localparam int IRQ_WIDE_A = 0;
	localparam int IRQ_NARROW_C = 1;
	localparam int IRQ_NARROW_D = 2;
	localparam int IRQ_WATCH = 3;
	localparam int IRQ_CSI = 4;
	localparam int IRQ_UART_A = 5;
	localparam int IRQ_UART_B = 6;

	// ==========================================================
	// Timing counts
	localparam int STAB_CYCLES_DEF = 16;

	// ==========================================================
	// Operating modes
	typedef enum logic [1:0] {
		PSV_NORMAL,
		PSV_IDLE,
		PSV_STOP,
		PSV_STAB
	} psv_state_type;

endpackage
`default_nettype wire

// *** core/psv_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module psv_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] level_o
);

	logic [W-1:0] meta;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	// ==========================================================
	// Synchroniser chain; only stage2 reads meta
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			meta <= pin_i;
			stage2 <= meta;
			stage3 <= stage2;
		end
	end

	// ==========================================================
	// A change counts only once two settled stages agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level_o <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (stage2[i] == stage3[i]) begin
					level_o[i] <= stage3[i];
				end
			end
		end
	end

endmodule
`default_nettype wire

// *** core/psv_ctrl.sv ***
// Power-save controller: IDLE and software STOP sequencing with clock gating
// Operation
// - Wake IDLE on NMI, live unmasked irq, reset
// - IDLE stops CPU, gates clocks, oscillators run
// - Wide timer A runs only on watch irq
// - Narrow timers C, D, watch need subclock
// - Clocked serial ports run on external clock
// - Async ports transmit only on external clock
// - Real-time output follows running subclock timer
// - STOP halts main oscillator, subclock keeps running
// - STOP halts execution, state retained
// - STOP stops peripherals except subclock and external-clock ones
// - No bus hold grant during STOP
// - STOP allowed only with main CPU clock
// - Writing stop bit enters STOP
// - Writing idle bit enters IDLE
// - IDLE release is immediate, no wait
// - No bus hold grant during IDLE
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module psv_ctrl #(
	parameter int STAB_CYCLES = psv_pkg::STAB_CYCLES_DEF
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic subclock_present_i,
	input wire logic cpu_clk_is_sub_i,
	input wire logic nmi_i,
	input wire logic [3:0] ext_irq_group_low_i,
	input wire logic [psv_pkg::IRQ_W-1:0] periph_irq_i,
	input wire logic bus_hold_request_i,
	output logic bus_hold_acknowledge_o,
	output logic cpu_run_o,
	output logic cpu_clk_en_o,
	output logic periph_clk_en_o,
	output logic main_osc_en_o,
	output logic sub_osc_en_o,
	output logic wide_timer_a_run_o,
	output logic wide_timer_b_run_o,
	output logic narrow_timers_ab_run_o,
	output logic narrow_timer_c_run_o,
	output logic narrow_timer_d_run_o,
	output logic watch_timer_run_o,
	output logic watchdog_run_o,
	output logic clocked_serial_ports_run_o,
	output logic async_serial_port_a_tx_run_o,
	output logic async_serial_port_b_tx_run_o,
	output logic async_serial_rx_run_o,
	output logic two_wire_serial_run_o,
	output logic adc_run_o,
	output logic dma_channels_run_o,
	output logic rtp_run_o,
	output logic port_hold_o,
	output logic ext_bus_oe_o,
	output logic ext_irq_group_low_en_o,
	output logic ext_irq_group_high_en_o,
	output logic nmi_en_o
);

	// ==========================================================
	// Declarations
	psv_pkg::psv_state_type state;
	logic [psv_pkg::CFG_W-1:0] cfg;
	logic [15:0] stab_cnt;
	logic sub_s;
	logic nmi_s;
	logic hold_s;
	logic [3:0] ext_low_s;
	logic write_fire;
	logic pw_wr;
	logic idle_req;
	logic stop_req;
	logic low_power;
	logic wake;
	logic [psv_pkg::IRQ_W-1:0] irq_live;
	logic [31:0] next_rdata;
	logic next_wa;
	logic next_nc;
	logic next_nd;
	logic next_wt;
	logic next_csi;
	logic next_ua;
	logic next_ub;
	logic next_rtp;

	// ==========================================================
	// Pin inputs cross into the clock domain
	psv_sync #(
		.W(7)
	) i_psv_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i({subclock_present_i, nmi_i, bus_hold_request_i,
			ext_irq_group_low_i}),
		.level_o({sub_s, nmi_s, hold_s, ext_low_s})
	);

	// ==========================================================
	// Wishbone slave: one wait state, ack pulses one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
		end
	end

	// Writes land on the edge at which the master sees ack
	assign write_fire = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
	assign pw_wr = write_fire & (wb_adr_i == psv_pkg::ADDR_SAVE) & wb_sel_i[0];
	assign idle_req = pw_wr & wb_dat_i[psv_pkg::IDLE_REQ_BIT];
	assign stop_req = pw_wr & wb_dat_i[psv_pkg::STOP_REQ_BIT];

	// Configuration register, byte lanes 0 and 1
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg <= psv_pkg::CFG_RESET;
		end else if (write_fire && wb_adr_i == psv_pkg::ADDR_CFG) begin
			if (wb_sel_i[0]) begin
				cfg[7:0] <= wb_dat_i[7:0];
			end
			if (wb_sel_i[1]) begin
				cfg[8] <= wb_dat_i[8];
			end
		end
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (wb_adr_i)
			psv_pkg::ADDR_SAVE: begin
				next_rdata[psv_pkg::IDLE_REQ_BIT] = (state == psv_pkg::PSV_IDLE);
				next_rdata[psv_pkg::STOP_REQ_BIT] = (state == psv_pkg::PSV_STOP);
			end
			psv_pkg::ADDR_CFG: begin
				next_rdata[psv_pkg::CFG_W-1:0] = cfg;
			end
			psv_pkg::ADDR_STAT: begin
				next_rdata[psv_pkg::STAT_MODE_LSB +: 2] = state;
				next_rdata[psv_pkg::STAT_SUB_PRESENT] = sub_s;
				next_rdata[psv_pkg::STAT_CPU_ON_SUB] = cpu_clk_is_sub_i;
				next_rdata[psv_pkg::STAT_MAIN_OSC] = main_osc_en_o;
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	// Read data is captured with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
			wb_dat_o <= next_rdata;
		end
	end

	// ==========================================================
	// Which subclock and external-clock functions keep running
	assign low_power = (state != psv_pkg::PSV_NORMAL);
	always_comb begin
		next_wa = sub_s & cfg[psv_pkg::CFG_WA_WTI];
		next_nc = sub_s & cfg[psv_pkg::CFG_NC_SUB];
		next_nd = sub_s & cfg[psv_pkg::CFG_ND_SUB];
		next_wt = sub_s & cfg[psv_pkg::CFG_WT_SUB];
		next_csi = cfg[psv_pkg::CFG_CSI_EXT];
		next_ua = cfg[psv_pkg::CFG_UA_EXT];
		next_ub = cfg[psv_pkg::CFG_UB_EXT];
		// Real-time output is only as alive as its trigger timer
		next_rtp = sub_s & ((cfg[psv_pkg::CFG_RTP_C] & next_nc) |
			(cfg[psv_pkg::CFG_RTP_D] & next_nd));
	end

	// A stopped peripheral cannot wake the device
	always_comb begin
		irq_live = '0;
		irq_live[psv_pkg::IRQ_WIDE_A] = next_wa;
		irq_live[psv_pkg::IRQ_NARROW_C] = next_nc;
		irq_live[psv_pkg::IRQ_NARROW_D] = next_nd;
		irq_live[psv_pkg::IRQ_WATCH] = next_wt;
		irq_live[psv_pkg::IRQ_CSI] = next_csi;
		irq_live[psv_pkg::IRQ_UART_A] = next_ua;
		irq_live[psv_pkg::IRQ_UART_B] = next_ub;
	end

	// NMI and low external irqs stay live in both low-power modes
	assign wake = nmi_s | (|ext_low_s) | (|(periph_irq_i & irq_live));

	// ==========================================================
	// Mode sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= psv_pkg::PSV_NORMAL;
		end else begin
			unique case (state)
				psv_pkg::PSV_NORMAL: begin
					// Stop needs the main clock on the CPU; refused otherwise
					if (stop_req && !cpu_clk_is_sub_i) begin
						state <= psv_pkg::PSV_STOP;
					end else if (idle_req) begin
						state <= psv_pkg::PSV_IDLE;
					end
				end
				psv_pkg::PSV_IDLE: begin
					// Oscillator never stopped, so return at once
					if (wake) begin
						state <= psv_pkg::PSV_NORMAL;
					end
				end
				psv_pkg::PSV_STOP: begin
					if (wake) begin
						state <= psv_pkg::PSV_STAB;
					end
				end
				psv_pkg::PSV_STAB: begin
					if (stab_cnt == 16'(STAB_CYCLES - 1)) begin
						state <= psv_pkg::PSV_NORMAL;
					end
				end
			endcase
		end
	end

	// Main oscillator restart wait after STOP
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stab_cnt <= 16'h0000;
		end else if (state == psv_pkg::PSV_STAB) begin
			stab_cnt <= stab_cnt + 16'h0001;
		end else begin
			stab_cnt <= 16'h0000;
		end
	end

	// ==========================================================
	// Registered clock, run and pin controls
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_run_o <= 1'b1;
			cpu_clk_en_o <= 1'b1;
			periph_clk_en_o <= 1'b1;
			main_osc_en_o <= 1'b1;
			sub_osc_en_o <= 1'b1;
			port_hold_o <= 1'b0;
			ext_bus_oe_o <= 1'b1;
			bus_hold_acknowledge_o <= 1'b0;
		end else begin
			// Halting the CPU clock freezes registers and RAM
			cpu_run_o <= ~low_power;
			cpu_clk_en_o <= ~low_power;
			periph_clk_en_o <= ~low_power;
			main_osc_en_o <= (state != psv_pkg::PSV_STOP);
			sub_osc_en_o <= 1'b1;
			port_hold_o <= low_power;
			ext_bus_oe_o <= ~low_power;
			bus_hold_acknowledge_o <= hold_s & ~low_power;
		end
	end

	// Peripheral run enables: all run in normal mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wide_timer_a_run_o <= 1'b1;
			narrow_timer_c_run_o <= 1'b1;
			narrow_timer_d_run_o <= 1'b1;
			watch_timer_run_o <= 1'b1;
			clocked_serial_ports_run_o <= 1'b1;
			async_serial_port_a_tx_run_o <= 1'b1;
			async_serial_port_b_tx_run_o <= 1'b1;
			rtp_run_o <= 1'b1;
		end else begin
			wide_timer_a_run_o <= ~low_power | next_wa;
			narrow_timer_c_run_o <= ~low_power | next_nc;
			narrow_timer_d_run_o <= ~low_power | next_nd;
			watch_timer_run_o <= ~low_power | next_wt;
			clocked_serial_ports_run_o <= ~low_power | next_csi;
			async_serial_port_a_tx_run_o <= ~low_power | next_ua;
			async_serial_port_b_tx_run_o <= ~low_power | next_ub;
			rtp_run_o <= ~low_power | next_rtp;
		end
	end

	// Blocks with no subclock path stop; NMI and the low external irq group stay enabled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wide_timer_b_run_o <= 1'b1;
			narrow_timers_ab_run_o <= 1'b1;
			watchdog_run_o <= 1'b1;
			async_serial_rx_run_o <= 1'b1;
			two_wire_serial_run_o <= 1'b1;
			adc_run_o <= 1'b1;
			dma_channels_run_o <= 1'b1;
			ext_irq_group_low_en_o <= 1'b1;
			ext_irq_group_high_en_o <= 1'b1;
			nmi_en_o <= 1'b1;
		end else begin
			wide_timer_b_run_o <= ~low_power;
			narrow_timers_ab_run_o <= ~low_power;
			watchdog_run_o <= ~low_power;
			async_serial_rx_run_o <= ~low_power;
			two_wire_serial_run_o <= ~low_power;
			adc_run_o <= ~low_power;
			dma_channels_run_o <= ~low_power;
			ext_irq_group_low_en_o <= 1'b1;
			ext_irq_group_high_en_o <= ~low_power;
			nmi_en_o <= 1'b1;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_idle_write;
		state == psv_pkg::PSV_NORMAL && idle_req && !stop_req;
	endsequence

	sequence s_stop_write;
		state == psv_pkg::PSV_NORMAL && stop_req && !cpu_clk_is_sub_i;
	endsequence

	sequence s_idle_gated;
		state == psv_pkg::PSV_IDLE ##1 !cpu_clk_en_o && main_osc_en_o;
	endsequence

	AST_IDLE_ENTRY: assert property (s_idle_write |=> s_idle_gated)
		else $error("idle write did not gate clocks");
	AST_STOP_ENTRY: assert property (s_stop_write |=>
		state == psv_pkg::PSV_STOP ##1 !main_osc_en_o && sub_osc_en_o)
		else $error("stop write did not halt main oscillator");
	AST_STOP_REFUSED: assert property (state == psv_pkg::PSV_NORMAL &&
		stop_req && cpu_clk_is_sub_i && !idle_req |=>
		state == psv_pkg::PSV_NORMAL)
		else $error("stop entered on subclock CPU clock");
	AST_IDLE_WAKE: assert property (state == psv_pkg::PSV_IDLE && wake |=>
		state == psv_pkg::PSV_NORMAL ##1 cpu_clk_en_o && cpu_run_o)
		else $error("idle wake not immediate");
	AST_IDLE_STAYS: assert property (state == psv_pkg::PSV_IDLE && !wake |=>
		state == psv_pkg::PSV_IDLE)
		else $error("idle left without wake");
	AST_NO_HOLD: assert property (low_power |=> !bus_hold_acknowledge_o)
		else $error("bus hold granted in low power mode");
	AST_WIDE_A: assert property (low_power && !sub_s |=>
		!wide_timer_a_run_o && !narrow_timer_c_run_o && !watch_timer_run_o)
		else $error("subclock timer ran without subclock");
	AST_RTP: assert property (low_power && sub_s && cfg[psv_pkg::CFG_RTP_C] &&
		cfg[psv_pkg::CFG_NC_SUB] |=> rtp_run_o && narrow_timer_c_run_o)
		else $error("real-time output stopped with running trigger");
	AST_IRQ_GROUPS: assert property (low_power |=>
		!ext_irq_group_high_en_o && ext_irq_group_low_en_o && !dma_channels_run_o)
		else $error("interrupt groups wrong in low power mode");
	AST_PINS: assert property (state == psv_pkg::PSV_IDLE |=>
		port_hold_o && !ext_bus_oe_o && !async_serial_rx_run_o)
		else $error("pins not held in idle");

endmodule
`default_nettype wire

// *** bench/psv_ctrl_tb.sv ***
// Self-checking bench for the power-save controller
`timescale 1ns/1ps
`default_nettype none

module psv_ctrl_tb;
	// ==========================================================
	// Stimulus and observation
	localparam int STAB = 4;
	localparam logic [17:0] ST_NORM = 18'h3FFDF;
	localparam logic [17:0] ST_IDLE = 18'h0602A;
	localparam logic [17:0] ST_STOP = 18'h0202A;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sub = 1'b1, cpu_sub = 1'b0;
	logic nmi = 1'b0, hreq = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h00000000;
	logic [3:0] ext_low = 4'h0;
	logic [6:0] pirq = 7'h00;
	logic [31:0] rdat, rd;
	logic cpu_run, cpu_clk, per_clk, main_osc, sub_osc, wide_a, wide_b, nab;
	logic nc, nd, watch, wdog, csi, ua, ub, rx, tw, adc, dma, rtp, phold;
	logic oe, low_en, high_en, nmi_en, hack, ack;
	logic [17:0] stat_v;
	logic [7:0] run_v;
	int num_errors = 0;
	int cmp_count = 0;
	assign stat_v = {cpu_run, cpu_clk, per_clk, main_osc, sub_osc, wide_b,
		nab, wdog, rx, tw, adc, dma, phold, oe, low_en, high_en, nmi_en, hack};
	assign run_v = {wide_a, nc, nd, watch, csi, ua, ub, rtp};

	psv_ctrl #(.STAB_CYCLES(STAB)) i_psv_ctrl (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.subclock_present_i(sub), .cpu_clk_is_sub_i(cpu_sub), .nmi_i(nmi),
		.ext_irq_group_low_i(ext_low), .periph_irq_i(pirq),
		.bus_hold_request_i(hreq), .bus_hold_acknowledge_o(hack),
		.cpu_run_o(cpu_run), .cpu_clk_en_o(cpu_clk), .periph_clk_en_o(per_clk),
		.main_osc_en_o(main_osc), .sub_osc_en_o(sub_osc),
		.wide_timer_a_run_o(wide_a), .wide_timer_b_run_o(wide_b),
		.narrow_timers_ab_run_o(nab), .narrow_timer_c_run_o(nc),
		.narrow_timer_d_run_o(nd), .watch_timer_run_o(watch),
		.watchdog_run_o(wdog), .clocked_serial_ports_run_o(csi),
		.async_serial_port_a_tx_run_o(ua), .async_serial_port_b_tx_run_o(ub),
		.async_serial_rx_run_o(rx), .two_wire_serial_run_o(tw),
		.adc_run_o(adc), .dma_channels_run_o(dma), .rtp_run_o(rtp),
		.port_hold_o(phold), .ext_bus_oe_o(oe),
		.ext_irq_group_low_en_o(low_en), .ext_irq_group_high_en_o(high_en),
		.nmi_en_o(nmi_en));

	// ==========================================================
	// Clock, verdict and hang guard
	initial begin
		forever #2 clk_i = ~clk_i;
	end

	task automatic complete_run();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		complete_run();
	end

	// ==========================================================
	// Shared helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Ack is read at the edge before that edge's updates land
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		for (n = 0; n < 20; n++) begin
			@(posedge clk_i);
			if (ack === 1'b1) break;
		end
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n == 20) begin
			num_errors++;
			complete_run();
		end
	endtask

	task automatic settle();
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
	endtask

	// Low-power run terms worked out from the configuration and subclock
	function automatic logic [7:0] exp_runs(input logic [8:0] c, input logic s);
		logic cr, dr;
		cr = s & c[1];
		dr = s & c[2];
		return {s & c[0], cr, dr, s & c[3], c[4], c[5], c[6],
			s & ((c[7] & cr) | (c[8] & dr))};
	endfunction

	// Bounded wait for the processor to run again; returns cycles waited
	task automatic wait_run(output int n);
		for (n = 1; n < 40; n++) begin
			@(negedge clk_i);
			if (cpu_run === 1'b1) break;
		end
		if (n == 40) begin
			num_errors++;
			complete_run();
		end
	endtask

	task automatic enter_idle(input logic [8:0] c);
		wb(1'b1, psv_pkg::ADDR_CFG, {23'h000000, c});
		wb(1'b1, psv_pkg::ADDR_SAVE, 32'h00000002);
		settle();
		chk(stat_v, ST_IDLE);
		chk(run_v, exp_runs(c, sub));
	endtask

	// ==========================================================
	// Scenarios
	task automatic sc_idle_periph_wake();
		enter_idle(9'h082);
		@(posedge clk_i);
		pirq[psv_pkg::IRQ_NARROW_D] <= 1'b1;
		repeat (4) @(posedge clk_i);
		@(negedge clk_i);
		chk(stat_v, ST_IDLE);
		@(posedge clk_i);
		pirq <= 7'h02; // Timer C request alone, one assignment
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		chk(stat_v, ST_NORM);
		@(posedge clk_i);
		pirq <= 7'h00;
	endtask

	task automatic sc_idle_pin_wake();
		int n;
		enter_idle(9'h171);
		@(posedge clk_i);
		ext_low <= 4'h8;
		wait_run(n);
		chk(n <= 8, 1'b1);
		@(posedge clk_i);
		ext_low <= 4'h0;
		settle();
		chk(stat_v, ST_NORM);
	endtask

	task automatic sc_stop_nmi();
		int n;
		wb(1'b1, psv_pkg::ADDR_CFG, 32'h0000000E);
		wb(1'b1, psv_pkg::ADDR_SAVE, 32'h00000003);
		settle();
		chk(stat_v, ST_STOP);
		chk(run_v, exp_runs(9'h00E, 1'b1));
		@(posedge clk_i);
		nmi <= 1'b1;
		wait_run(n);
		chk(n > STAB && n <= STAB + 8, 1'b1);
		@(posedge clk_i);
		nmi <= 1'b0;
		settle();
		chk(stat_v, ST_NORM);
	endtask

	task automatic sc_stop_refused();
		@(posedge clk_i);
		cpu_sub <= 1'b1;
		wb(1'b1, psv_pkg::ADDR_SAVE, 32'h00000001);
		settle();
		chk(stat_v, ST_NORM);
		wb(1'b0, psv_pkg::ADDR_STAT, 32'h00000000);
		chk(rd, 32'h0000001C);
		cpu_sub <= 1'b0;
		wb(1'b0, 8'h0C, 32'h00000000);
		chk(rd, 32'h00000000);
	endtask

	task automatic sc_reset_wake();
		// Subclock absent: only external-clock functions may keep running
		@(posedge clk_i);
		sub <= 1'b0;
		enter_idle(9'h1FF);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		@(negedge clk_i);
		chk(stat_v, ST_NORM);
		wb(1'b0, psv_pkg::ADDR_CFG, 32'h00000000);
		chk(rd, 32'h00000000);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk(stat_v, ST_NORM & 18'h3FFDE);
		chk(run_v, 8'hFF);
		@(posedge clk_i);
		hreq <= 1'b1;
		settle();
		settle();
		chk(stat_v, ST_NORM);
		sc_idle_periph_wake();
		sc_idle_pin_wake();
		sc_stop_nmi();
		sc_stop_refused();
		sc_reset_wake();
		complete_run();
	end
endmodule
`default_nettype wire
